// ### logic/wrw_defines.svh
// shared constants for the working register window block
`ifndef WRW_DEFINES_SVH
`define WRW_DEFINES_SVH
`define WRW_ADDR_HIGH  7'h7D
`define WRW_ADDR_LOW   7'h7E
`define WRW_GR_BANK    4'h0
`define WRW_ROW_LSB    1
`define WRW_ROW_MSB    3
`define WRW_PTR_RESET  4'h0
`define WRW_NIB_ZERO   4'h0
`endif

// ### logic/wrw_pkg.sv
// types for the working register window block
package wrw_pkg;
  typedef enum logic [3:0]
  {
    WRW_OP_ADD  = 4'h0,
    WRW_OP_ADD_WITH_CARRY = 4'h1,
    WRW_OP_SUB  = 4'h2,
    WRW_OP_SUBTRACT_WITH_BORROW = 4'h3,
    WRW_OP_AND  = 4'h4,
    WRW_OP_OR   = 4'h5,
    WRW_OP_XOR  = 4'h6,
    WRW_OP_LD   = 4'h7,
    WRW_OP_ST   = 4'h8,
    WRW_OP_MVI  = 4'h9,
    WRW_OP_MVO  = 4'hA,
    WRW_OP_ROR  = 4'hB
  } wrw_op_type;
  typedef enum logic [4:0]
  {
    WRW_S_IDLE = 5'h01,
    WRW_S_RDG  = 5'h02,
    WRW_S_RDM  = 5'h04,
    WRW_S_WR   = 5'h08,
    WRW_S_DONE = 5'h10
  } wrw_state_type;
endpackage

// ### logic/wrw_mem.sv
// data memory with registered read data
`timescale 1ns/1ps
module wrw_mem #(
  parameter int AW = 11
) (
  input  wire logic          clk,     // clock
  input  wire logic [AW-1:0] raddr,   // read address
  output logic      [3:0]    rdata,   // registered read data
  input  wire logic          we,      // write strobe
  input  wire logic [AW-1:0] waddr,   // write address
  input  wire logic [3:0]    wdata    // write data
);
  initial if (AW < 8) $error("address width too small");
  logic [3:0] mem [0:(1<<AW)-1];
  // synchronous read and write
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule // wrw_mem

// ### logic/wrw_core.sv
// working register window address generation and datapath
`timescale 1ns/1ps
`include "wrw_defines.svh"
// Overview of operation
// - sixteen nibbles of one row form the window; operand picks column
// - pointer is eight bits, upper four read zero; rows 0 to 7 of bank 0
// - window row comes from low pointer nibble bits 3 to 1
// - window address is bank 0, pointer row, operand column, any bank selected
// - memory operand uses bank register plus instruction row and column
// - add memory to window word and write sum back in one instruction
// - add with carry and subtract with borrow include the carry flag
// - and, or, xor of window and memory, result into window
// - load memory into window, store window into memory
// - indirect store with enable 1 uses pointer row and window contents column
// - indirect store with enable 0 uses bank, operand row, window column
// - indirect load reads the same indirect address as indirect store
// - indirect transfers use window contents as column address, not data
// - rotate window word right through carry
// - no window forms with immediate data; those go through selected bank
// - window words other than the pointer nibbles at 7D and 7E are ordinary memory, reachable by all memory instructions
// - pointer nibbles at 7D and 7E, same in every bank
// - carry set on carry or borrow, cleared otherwise
// - compare flag on add and subtract forms keeps carry updates but suppresses the result write
module wrw_core
  import wrw_pkg::*;
#(
  parameter int BANK_W = 4
) (
  input  wire logic             clk,         // clock
  input  wire logic             rst_n,       // async reset, active low
  input  wire logic             start,       // start one instruction, pulse
  input  wire wrw_pkg::wrw_op_type op,       // instruction
  input  wire logic [3:0]       r_col,       // window column operand
  input  wire logic [6:0]       m_addr,      // memory row and column operand
  input  wire logic [BANK_W-1:0] bank_sel,   // bank register value
  input  wire logic [2:0]       mem_row_ptr, // memory row pointer
  input  wire logic             ptr_en,      // row pointer enable flag
  input  wire logic             cmp_flag,    // compare no store flag
  input  wire logic             carry_in,    // carry flag
  output logic                  busy,        // instruction in progress
  output logic                  done,        // instruction finished, pulse
  output logic                  carry_out,   // new carry flag
  output logic                  carry_we,    // carry update strobe, pulse
  output logic [3:0]            ptr_high,    // high pointer nibble view
  output logic [3:0]            ptr_low      // low pointer nibble view
);
  import wrw_pkg::*;
  localparam int AW = BANK_W + 7;
  localparam logic [BANK_W-1:0] WIN_BANK = BANK_W'(`WRW_GR_BANK); // window bank at bank width
  initial if (BANK_W < 1 || BANK_W > 4) $error("bank width unsupported");

  // ==================================================
  // reset release
  logic rst_s1, rst_s2;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rstn = rst_s2;

  // ==================================================
  // state and operand capture
  wrw_state_type st_reg;
  wrw_op_type    op_reg;
  logic [3:0]    rc_reg, gval_reg;
  logic [6:0]    ma_reg;
  logic [BANK_W-1:0] bk_reg;
  logic [2:0]    mp_reg;
  logic          pe_reg, cmp_reg, cy_reg;
  logic [3:0]    row_ptr_reg;   // low pointer nibble storage
  logic [AW-1:0] raddr, waddr;
  logic [3:0]    rdata, wdata;
  logic [3:0]    rdata_or_ptr;  // read data with pointer nibbles mapped in
  logic          we;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_reg  <= WRW_OP_ADD;
      rc_reg  <= `WRW_NIB_ZERO;
      ma_reg  <= 7'h00;
      bk_reg  <= '0;
      mp_reg  <= 3'h0;
      pe_reg  <= 1'b0;
      cmp_reg <= 1'b0;
      cy_reg  <= 1'b0;
    end
    else if (start && st_reg == WRW_S_IDLE)
    begin
      op_reg  <= op;
      rc_reg  <= r_col;
      ma_reg  <= m_addr;
      bk_reg  <= bank_sel;
      mp_reg  <= mem_row_ptr;
      pe_reg  <= ptr_en;
      cmp_reg <= cmp_flag;
      cy_reg  <= carry_in;
    end
  end

  // ==================================================
  // address generation
  logic [AW-1:0] gr_addr, m_full, ind_addr, m_sysmap;
  wire [2:0] win_row = row_ptr_reg[`WRW_ROW_MSB:`WRW_ROW_LSB];
  always_comb
  begin
    // window: bank 0, pointer row, operand column
    gr_addr = {WIN_BANK, win_row, rc_reg};
    // memory operand from bank register
    m_full = {bk_reg, ma_reg};
    // control area shows the same contents in every bank
    m_sysmap = (ma_reg == `WRW_ADDR_HIGH || ma_reg == `WRW_ADDR_LOW)
             ? {WIN_BANK, ma_reg} : m_full;
    // window word used as column address
    if (pe_reg)
      ind_addr = {WIN_BANK, mp_reg, gval_reg};
    else
      ind_addr = {bk_reg, ma_reg[6:4], gval_reg};
  end

  // ==================================================
  // sequencer: read window, read memory, write
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_reg <= WRW_S_IDLE;
    else
      unique case (st_reg)
        WRW_S_IDLE: if (start) st_reg <= WRW_S_RDG;
        WRW_S_RDG:  st_reg <= WRW_S_RDM;
        WRW_S_RDM:  st_reg <= WRW_S_WR;
        WRW_S_WR:   st_reg <= WRW_S_DONE;
        WRW_S_DONE: st_reg <= WRW_S_IDLE;
        default:    st_reg <= WRW_S_IDLE;
      endcase
  end

  // window value latched at the end of RDM, when the window read data arrives
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      gval_reg <= `WRW_NIB_ZERO;
    else if (st_reg == WRW_S_RDM)
      gval_reg <= rdata_or_ptr;
  end

  // read address per phase; indirect load reads the indirect address
  // the window word is only on the read data in RDM, so the column comes from there
  always_comb
  begin
    raddr = gr_addr;
    if (st_reg == WRW_S_RDM)
      raddr = (op_reg == WRW_OP_MVO) ? {ind_addr[AW-1:4], rdata_or_ptr} : m_sysmap;
  end
  // the window read lands in RDM, the memory read lands in WR
  logic [AW-1:0] last_raddr;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) last_raddr <= '0;
    else last_raddr <= raddr;
  end
  always_comb
  begin
    // pointer reads in any bank, upper bits zero
    if (last_raddr[6:0] == `WRW_ADDR_HIGH)
      rdata_or_ptr = `WRW_NIB_ZERO;
    else if (last_raddr[6:0] == `WRW_ADDR_LOW)
      rdata_or_ptr = row_ptr_reg;
    else
      rdata_or_ptr = rdata;
  end

  // ==================================================
  // arithmetic and logic
  logic [4:0] sum;
  logic [3:0] res;
  logic       cy_new, arith, stores_gr;
  always_comb
  begin
    sum = 5'h00;
    res = gval_reg;
    arith = 1'b0;
    stores_gr = 1'b1;
    cy_new = cy_reg;
    unique case (op_reg) // register-memory forms only, no immediate data
      WRW_OP_ADD:  begin sum = {1'b0, gval_reg} + {1'b0, rdata_or_ptr}; arith = 1'b1; end
      WRW_OP_ADD_WITH_CARRY: begin sum = {1'b0, gval_reg} + {1'b0, rdata_or_ptr} + {4'h0, cy_reg}; arith = 1'b1; end
      WRW_OP_SUB:  begin sum = {1'b0, gval_reg} - {1'b0, rdata_or_ptr}; arith = 1'b1; end
      WRW_OP_SUBTRACT_WITH_BORROW: begin sum = {1'b0, gval_reg} - {1'b0, rdata_or_ptr} - {4'h0, cy_reg}; arith = 1'b1; end
      WRW_OP_AND:  res = gval_reg & rdata_or_ptr;
      WRW_OP_OR:   res = gval_reg | rdata_or_ptr;
      WRW_OP_XOR:  res = gval_reg ^ rdata_or_ptr;
      WRW_OP_LD:   res = rdata_or_ptr;
      WRW_OP_ROR:  begin res = {cy_reg, gval_reg[3:1]}; cy_new = gval_reg[0]; end
      default:     stores_gr = 1'b0;
    endcase
    if (arith)
    begin
      res = sum[3:0];
      cy_new = sum[4];
    end
  end

  // ==================================================
  // write back
  always_comb
  begin
    we = 1'b0;
    waddr = gr_addr;
    wdata = res;
    if (st_reg == WRW_S_WR)
    begin
      if (stores_gr)
        we = !(arith && cmp_reg);
      else if (op_reg == WRW_OP_ST)
      begin
        we = 1'b1;
        waddr = m_sysmap;
        wdata = gval_reg;
      end
      else if (op_reg == WRW_OP_MVI)
      begin
        we = 1'b1;
        waddr = ind_addr;
        wdata = rdata_or_ptr;
      end
      else if (op_reg == WRW_OP_MVO)
      begin
        we = 1'b1;
        waddr = m_sysmap;
        wdata = rdata_or_ptr;
      end
    end
  end
  // pointer writes land in the register whatever bank is addressed
  wire ptr_hit = we && waddr[6:0] == `WRW_ADDR_LOW;

  // low pointer nibble: only written through the control area
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) row_ptr_reg <= `WRW_PTR_RESET;
    else if (ptr_hit) row_ptr_reg <= wdata;
  end

  wrw_mem #(.AW(AW)) u_mem (
    .clk   (clk),
    .raddr (raddr),
    .rdata (rdata),
    .we    (we && !ptr_hit),
    .waddr (waddr),
    .wdata (wdata)
  );

  // ==================================================
  // outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy      <= 1'b0;
      done      <= 1'b0;
      carry_out <= 1'b0;
      carry_we  <= 1'b0;
      ptr_high  <= `WRW_NIB_ZERO;
      ptr_low   <= `WRW_PTR_RESET;
    end
    else
    begin
      busy      <= (st_reg != WRW_S_IDLE && st_reg != WRW_S_DONE) || (start && st_reg == WRW_S_IDLE);
      done      <= (st_reg == WRW_S_WR);
      carry_we  <= (st_reg == WRW_S_WR) && (arith || op_reg == WRW_OP_ROR);
      if (st_reg == WRW_S_WR) carry_out <= cy_new;
      ptr_high  <= `WRW_NIB_ZERO;
      ptr_low   <= ptr_hit ? wdata : row_ptr_reg;
    end
  end

  // ==================================================
  // checks
  a_win_bank_zero: assert property (@(posedge clk) disable iff (!rstn)
    gr_addr[AW-1:7] == '0 && gr_addr[6:4] == row_ptr_reg[`WRW_ROW_MSB:`WRW_ROW_LSB]
      && gr_addr[3:0] == rc_reg)
    else $error("window address outside bank zero rows");
  a_done_spacing: assert property (@(posedge clk) disable iff (!rstn)
    (start && st_reg == WRW_S_IDLE) |-> ##4 done)
    else $error("instruction did not finish in four cycles");
  a_cmp_no_write: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg == WRW_S_WR && arith && cmp_reg) |-> !we)
    else $error("compare wrote a result");
  a_ptr_high_zero: assert property (@(posedge clk) disable iff (!rstn)
    ptr_high == `WRW_NIB_ZERO)
    else $error("high pointer nibble not zero");
  a_ror_carry: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg == WRW_S_WR && op_reg == WRW_OP_ROR) |=> carry_out == $past(gval_reg[0]))
    else $error("rotate carry wrong");
  a_carry_add: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg == WRW_S_WR && op_reg == WRW_OP_ADD) |=>
      carry_out == (({1'b0, $past(gval_reg)} + {1'b0, $past(rdata_or_ptr)}) > 5'h0F))
    else $error("add carry wrong");
  a_ind_column: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg == WRW_S_WR && op_reg == WRW_OP_MVI) |-> waddr[3:0] == gval_reg)
    else $error("indirect column not window contents");
  a_st_data: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg == WRW_S_WR && op_reg == WRW_OP_ST) |-> we && wdata == gval_reg)
    else $error("store data wrong");
  a_mvo_src_col: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg == WRW_S_WR && op_reg == WRW_OP_MVO) |-> last_raddr[3:0] == gval_reg)
    else $error("indirect load source column not window contents");
endmodule // wrw_core

// ### test/tb_top.sv
// self-checking bench for the working register window core
`timescale 1ns/1ps
module tb_top;
  import wrw_pkg::*;
  // ==========
  // stimulus signals and design hookup
  logic        clk         = 1'b0;
  logic        rst_n       = 1'b0;
  logic        start       = 1'b0;
  wrw_op_type  op          = WRW_OP_ADD;
  logic [3:0]  r_col       = 4'h0;
  logic [6:0]  m_addr      = 7'h00;
  logic [3:0]  bank_sel    = 4'h0;
  logic [2:0]  mem_row_ptr = 3'h0;
  logic        ptr_en      = 1'b0;
  logic        cmp_flag    = 1'b0;
  logic        carry_in    = 1'b0;
  logic        busy;
  logic        done;
  logic        carry_out;
  logic        carry_we;
  logic [3:0]  ptr_high;
  logic [3:0]  ptr_low;
  int          bad_count   = 0;
  int          compares    = 0;
  int          cycles      = 0;
  logic [31:0] seed        = 32'h2964981D;
  logic [3:0]  mem [0:2047];
  logic [3:0]  ptr_m       = 4'h0;
  logic [10:0] ga;
  logic [10:0] ma;
  logic [10:0] ia;
  logic [3:0]  g;
  logic [3:0]  m;
  logic        ok;

  // free running clock, 8 ns period
  always #4 clk = ~clk;

  wrw_core uut (.clk(clk), .rst_n(rst_n), .start(start), .op(op), .r_col(r_col),
    .m_addr(m_addr), .bank_sel(bank_sel), .mem_row_ptr(mem_row_ptr), .ptr_en(ptr_en),
    .cmp_flag(cmp_flag), .carry_in(carry_in), .busy(busy), .done(done),
    .carry_out(carry_out), .carry_we(carry_we), .ptr_high(ptr_high), .ptr_low(ptr_low));

  // ==========
  // reference model of memory and pointer
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // system nibbles show through in every bank
  function automatic logic [3:0] rd(input logic [10:0] a);
    return (a[6:0] == 7'h7E) ? ptr_m : (a[6:0] == 7'h7D) ? 4'h0 : mem[a];
  endfunction

  task automatic wr(input logic [10:0] a, input logic [3:0] v);
    if (a[6:0] == 7'h7E)
      ptr_m = v;
    else if (a[6:0] != 7'h7D)
      mem[a] = v;
  endtask

  // operand addresses and whether the model knows every read value
  task automatic addr();
    ga = {4'h0, ptr_m[3:1], r_col};
    ma = {bank_sel, m_addr};
    g = rd(ga);
    m = rd(ma);
    ia = ptr_en ? {4'h0, mem_row_ptr, g} : {bank_sel, m_addr[6:4], g};
    ok = (op == WRW_OP_LD || !$isunknown(g))
      && (op inside {WRW_OP_ST, WRW_OP_ROR, WRW_OP_MVO} || !$isunknown(m))
      && (op != WRW_OP_MVO || !$isunknown(rd(ia)));
  endtask

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk4({3'h0, got}, {3'h0, exp}, what);
  endtask

  // ==========
  // one instruction: predict, issue, check outcome
  task automatic run(input logic poke);
    logic [4:0] t;
    logic       cwe;
    logic       cy;
    int         n;
    t = op[1] ? {1'b0, g} - {1'b0, m} - 5'(op[0] & carry_in)
              : {1'b0, g} + {1'b0, m} + 5'(op[0] & carry_in);
    cwe = (op <= WRW_OP_SUBTRACT_WITH_BORROW) || (op == WRW_OP_ROR);
    cy = (op == WRW_OP_ROR) ? g[0] : t[4];
    case (op)
      WRW_OP_AND: wr(ga, g & m);
      WRW_OP_OR:  wr(ga, g | m);
      WRW_OP_XOR: wr(ga, g ^ m);
      WRW_OP_LD:  wr(ga, m);
      WRW_OP_ST:  wr(ma, g);
      WRW_OP_MVI: wr(ia, m);
      WRW_OP_MVO: wr(ma, rd(ia));
      WRW_OP_ROR: wr(ga, {carry_in, g[3:1]});
      default:    if (!cmp_flag) wr(ga, t[3:0]);
    endcase
    start = 1'b1;
    @(negedge clk);
    start = poke;
    chk1(busy, 1'b1, "busy level");
    @(negedge clk);
    start = 1'b0;
    // a value seen at a falling edge is what the next rising edge samples
    n = 2;
    while (done !== 1'b1 && n < 12)
    begin
      @(negedge clk);
      n++;
    end
    chk4(4'(n), 4'h4, "done latency");
    chk1(carry_we, cwe, "carry strobe");
    if (cwe)
      chk1(carry_out, cy, "carry value");
    chk4(ptr_low, ptr_m, "low pointer");
    chk4(ptr_high, 4'h0, "high pointer");
    @(negedge clk);
    chk1(done, 1'b0, "done pulse");
    chk1(busy, 1'b0, "busy idle");
  endtask

  // directed instruction on the low pointer address in a foreign bank
  task automatic go(input wrw_op_type o, input logic [3:0] r, input logic ci, input logic pk);
    op = o;
    r_col = r;
    carry_in = ci;
    m_addr = 7'h7E;
    bank_sel = 4'h5;
    addr();
    run(pk);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 9000)
    begin
      bad_count++;
      test_done();
    end
  end

  // main sequence
  initial
  begin
    logic [31:0] w;
    int          tries;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk4(ptr_high, 4'h0, "reset high");
    chk4(ptr_low, 4'h0, "reset low");
    chk1(busy, 1'b0, "reset busy");
    go(WRW_OP_LD, 4'h0, 1'b0, 1'b0);
    go(WRW_OP_ROR, 4'h0, 1'b1, 1'b0);
    go(WRW_OP_ST, 4'h0, 1'b0, 1'b0);
    go(WRW_OP_LD, 4'h3, 1'b0, 1'b0);
    go(WRW_OP_ADD, 4'h3, 1'b0, 1'b1);
    go(WRW_OP_ADD_WITH_CARRY, 4'h3, 1'b1, 1'b0);
    go(WRW_OP_ST, 4'h3, 1'b0, 1'b0);
    go(WRW_OP_ADD, 4'h3, 1'b0, 1'b0);
    $display("test directed done");
    repeat (400)
    begin
      tries = 0;
      do
      begin
        w = rnd();
        op = wrw_op_type'(4'(w[3:0] % 4'hC));
        r_col = w[7:4];
        m_addr = (w[9:8] == 2'h0) ? 7'h7E : w[16:10];
        bank_sel = (m_addr == 7'h7E) ? w[21:18] : {3'h0, w[18]};
        mem_row_ptr = w[24:22];
        ptr_en = w[25];
        cmp_flag = w[26] & w[27];
        carry_in = w[28];
        addr();
        tries++;
      end
      while (!ok && tries < 200);
      if (ok)
        run(w[29] & w[30]);
    end
    $display("test random done");
    test_done();
  end
endmodule // tb_top
